// >>> design/mpc_pkg.sv
// Shared constants and types for the mode parameter checker link.
package mpc_pkg;
  localparam int unsigned BUF_DEPTH = 32;
  // Select stream: flag byte, descriptor length byte, descriptor, pages.
  localparam int unsigned WIDE_BIT = 0;
  localparam logic [7:0] DLEN_NONE  = 8'h00;
  localparam logic [7:0] DLEN_SHORT = 8'h08;
  localparam logic [7:0] DLEN_LONG  = 8'h10;
  localparam logic [7:0] CNT_BYTES_SHORT = 8'h04;
  localparam logic [7:0] CNT_BYTES_LONG  = 8'h08;
  localparam logic [7:0] LEN_POS_SHORT   = 8'h05;
  localparam logic [7:0] LEN_POS_LONG    = 8'h0C;
  localparam logic [63:0] CNT_ONES_SHORT = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] CNT_ONES_LONG  = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [23:0] BLEN_512  = 24'h00_0200;
  localparam logic [23:0] BLEN_520  = 24'h00_0208;
  localparam logic [23:0] BLEN_528  = 24'h00_0210;
  localparam logic [23:0] BLEN_4096 = 24'h00_1000;
  localparam logic [23:0] BLEN_4112 = 24'h00_1010;
  localparam logic [23:0] BLEN_4160 = 24'h00_1040;
  localparam logic [23:0] BLEN_4224 = 24'h00_1080;
  localparam logic [23:0] BLEN_RESET = 24'h00_0200;
  // Page header fields.
  localparam int unsigned PS_BIT  = 7;
  localparam int unsigned SPF_BIT = 6;
  localparam logic [5:0] PG_VU   = 6'h00;
  localparam logic [5:0] PG_RW   = 6'h01;
  localparam logic [5:0] PG_FMT  = 6'h03;
  localparam logic [5:0] PG_GEOM = 6'h04;
  localparam logic [7:0] PLEN_VU   = 8'h0E;
  localparam logic [7:0] PLEN_RW   = 8'h0A;
  localparam logic [7:0] PLEN_DFLT = 8'h0A;
  // Page 00 layout.
  localparam int unsigned MERGE_BYTE = 2;
  localparam int unsigned MERGE_BIT  = 3;
  localparam int unsigned SEEK_BYTE  = 3;
  localparam int unsigned SEEK_BIT   = 6;
  localparam int unsigned RRND_BIT   = 1;
  localparam int unsigned FDD_BYTE   = 5;
  localparam int unsigned FDD_BIT    = 4;
  localparam int unsigned QUEUE_AGING_ENABLE_BIT   = 1;
  localparam int unsigned AGE_HI     = 10;
  localparam int unsigned AGE_LO     = 11;
  localparam int unsigned BODY_OFS   = 2;
  typedef logic [0:15][7:0] mpc_page_t;
  localparam mpc_page_t PG0_DFLT = {8'h80, 8'h0E, 8'h00, 8'h00,
    8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30,
    8'h16, 8'h14, 8'h00, 8'h00};
  localparam mpc_page_t PG0_WMASK = {8'h00, 8'h00, 8'h09, 8'h42,
    8'h00, 8'h13, 8'hCF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hB4};
  // Check Condition sense: illegal request, invalid field in list.
  localparam logic [3:0] KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_BAD_PARAM = 8'h26;
  // Host register map.
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_LEN    = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_BUF    = 8'h80;
  localparam int unsigned CTRL_SEL   = 0;
  localparam int unsigned CTRL_SENSE = 1;
  localparam int unsigned CTRL_WIDE  = 2;
endpackage

// >>> design/mpc_link_if.sv
// Link between the initiator end and the device end.
`timescale 1ns/1ps
interface mpc_link_if;
  logic       sel_valid;
  logic       sel_ready;
  logic [7:0] sel_data;
  logic       sel_last;
  logic       sense_req;
  logic       sense_wide;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       done;
  logic       check;
  logic [3:0] sense_key;
  logic [7:0] asc;
  modport dev (
    input  sel_valid, sel_data, sel_last, sense_req, sense_wide,
    output sel_ready, rsp_valid, rsp_data, rsp_last, done, check,
           sense_key, asc
  );
  modport host (
    output sel_valid, sel_data, sel_last, sense_req, sense_wide,
    input  sel_ready, rsp_valid, rsp_data, rsp_last, done, check,
           sense_key, asc
  );
endinterface

// >>> design/mpc_device.sv
// Device end: checks MODE SELECT data, keeps page 00, answers MODE SENSE.
`timescale 1ns/1ps
module mpc_device
  import mpc_pkg::*;
#(
  parameter logic [63:0] MAX_BLOCKS = 64'h0000_0000_0100_0000,
  parameter bit          SUPPORT_4K = 1'b1
)(
  // Clock and reset.
  input  wire logic        I_REF_CLK,
  input  wire logic        I_SYS_RST,
  // Link to the initiator.
  mpc_link_if.dev          LINK,
  // Drive events, same clock.
  input  wire logic        I_FORMAT_UNIT,
  input  wire logic        I_STOP_UNIT,
  input  wire logic        I_START_UNIT,
  input  wire logic        I_PER_ENABLE,
  input  wire logic        I_NONDATA_ERR,
  input  wire logic        I_FORMAT_DEGRADED,
  input  wire logic [15:0] I_QUEUE_WAIT,
  // Drive state.
  output logic      [63:0] O_USER_BLOCKS,
  output logic      [23:0] O_BLOCK_LENGTH,
  output logic             O_FORMAT_PENDING,
  output logic             O_DEFECT_MERGE,
  output logic             O_SELF_SEEK,
  output logic             O_NONDATA_REPORT,
  output logic             O_TUR_DEGRADED,
  output logic             O_MEDIA_DEGRADED,
  output logic             O_QUEUE_FIFO
);
  typedef enum logic [2:0] {
    ST_FLAGS = 3'b000,
    ST_DLEN  = 3'b001,
    ST_DESC  = 3'b010,
    ST_PHDR  = 3'b011,
    ST_PLEN  = 3'b100,
    ST_BODY  = 3'b101,
    ST_SENSE = 3'b110
  } mpc_dst_t;

  typedef struct packed {
    mpc_dst_t    st;
    logic [7:0]  idx;
    logic        wide;
    logic [7:0]  dlen;
    logic [63:0] cnt;
    logic [23:0] blen;
    logic        err;
    logic [5:0]  pcode;
    logic [7:0]  plen;
    mpc_page_t   stage;
    mpc_page_t   cur;
    logic [63:0] blocks;
    logic [63:0] pend_cnt;
    logic        pend_wide;
    logic [23:0] cur_blen;
    logic [23:0] pend_blen;
    logic        pend;
    logic        spin;
    logic        armed;
    logic        seek;
    logic        done;
    logic        check;
    logic        rvalid;
    logic        rlast;
    logic [7:0]  rdata;
    logic        merge;
    logic        ndr;
    logic        tur;
    logic        media;
    logic        fifo;
  } mpc_dstate_t;

  mpc_dstate_t r_r;
  mpc_dstate_t r_nxt;
  logic        sel_take;
  logic [7:0]  b;

  function automatic logic [63:0] ones(input logic w);
    return w ? CNT_ONES_LONG : CNT_ONES_SHORT;
  endfunction

  function automatic logic blen_ok(input logic [23:0] l);
    logic base;
    logic big;
    base = (l == BLEN_512) || (l == BLEN_520) || (l == BLEN_528) ||
           (l == '0);
    big = (l == BLEN_4096) || (l == BLEN_4112) || (l == BLEN_4160) ||
          (l == BLEN_4224);
    return base || (SUPPORT_4K && big);
  endfunction

  function automatic logic [63:0] apply_cnt(input logic [63:0] c,
      input logic w, input logic [63:0] cur);
    if (c == '0)
      return cur;
    else if (c == ones(w))
      return MAX_BLOCKS;
    else
      return c;
  endfunction

  function automatic logic supported(input logic [5:0] c);
    unique case (c)
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h08, 6'h0A, 6'h0C,
      6'h19, 6'h1A, 6'h1C: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] page_len(input logic [5:0] c);
    if (c == PG_VU)
      return PLEN_VU;
    else if (c == PG_RW)
      return PLEN_RW;
    else
      return PLEN_DFLT;
  endfunction

  function automatic logic savable(input logic [5:0] c);
    return (c != PG_FMT) && (c != PG_GEOM);
  endfunction

  function automatic logic [7:0] sense_byte(input logic [7:0] i,
      input logic w, input mpc_dstate_t s);
    logic [7:0] d;
    logic [7:0] p;
    d = w ? DLEN_LONG : DLEN_SHORT;
    p = i - d;
    if (i >= d)
    begin
      if (p == 8'h00)
        return {savable(PG_VU), 1'b0, PG_VU};
      else if (p == 8'h01)
        return PLEN_VU;
      else
        return s.cur[p[3:0]];
    end
    else if (w)
    begin
      if (i < CNT_BYTES_LONG)
        return 8'(s.blocks >> {(3'd7 - i[2:0]), 3'b000});
      else if (i < LEN_POS_LONG)
        return 8'h00;
      else
        return 8'(s.cur_blen >> {(2'd3 - i[1:0]), 3'b000});
    end
    else if (i < CNT_BYTES_SHORT)
      return 8'(s.blocks >> {(2'd3 - i[1:0]), 3'b000});
    else if (i < LEN_POS_SHORT)
      return 8'h00;
    else
      return 8'(s.cur_blen >> {(3'd7 - i[2:0]), 3'b000});
  endfunction

  assign LINK.sel_ready = (r_r.st != ST_SENSE) &&
                          !((r_r.st == ST_FLAGS) && LINK.sense_req);
  assign sel_take = LINK.sel_valid && LINK.sel_ready;
  assign b = LINK.sel_data;

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    r_nxt.merge = 1'b0;
    r_nxt.rvalid = 1'b0;
    r_nxt.rlast = 1'b0;
    // Format is applied first, so a descriptor left pending by a select
    // that ends in the same cycle is kept rather than lost.
    if (I_FORMAT_UNIT)
    begin
      r_nxt.merge = r_r.cur[MERGE_BYTE][MERGE_BIT];
      if (r_r.pend)
      begin
        r_nxt.pend = 1'b0;
        r_nxt.cur_blen = r_r.pend_blen;
        r_nxt.blocks = apply_cnt(r_r.pend_cnt, r_r.pend_wide, r_r.blocks);
      end
    end
    if (sel_take)
    begin
      r_nxt.idx = r_r.idx + 8'h01;
      unique case (r_r.st)
        ST_FLAGS:
        begin
          r_nxt.wide = b[WIDE_BIT];
          r_nxt.err = 1'b0;
          r_nxt.cnt = '0;
          r_nxt.blen = '0;
          r_nxt.stage = r_r.cur;
          r_nxt.st = ST_DLEN;
        end
        ST_DLEN:
        begin
          r_nxt.dlen = b;
          r_nxt.idx = '0;
          r_nxt.st = (b == DLEN_NONE) ? ST_PHDR : ST_DESC;
          if (!((b == DLEN_NONE) || (b == DLEN_SHORT && !r_r.wide) ||
                (b == DLEN_LONG && r_r.wide)))
            r_nxt.err = 1'b1;
        end
        ST_DESC:
        begin
          if (r_r.idx < (r_r.wide ? CNT_BYTES_LONG : CNT_BYTES_SHORT))
            r_nxt.cnt = {r_r.cnt[55:0], b};
          else if (r_r.idx >= (r_r.wide ? LEN_POS_LONG : LEN_POS_SHORT))
          begin
            // A nonzero byte shifted out makes the length too large.
            r_nxt.blen = {r_r.blen[15:0], b};
            if (r_r.blen[23:16] != 8'h00)
              r_nxt.err = 1'b1;
          end
          else if (b != 8'h00)
            r_nxt.err = 1'b1;
          if (r_r.idx == r_r.dlen - 8'h01)
          begin
            r_nxt.st = ST_PHDR;
            if (!blen_ok(r_nxt.blen))
              r_nxt.err = 1'b1;
            if (!((r_r.cnt == '0) || (r_r.cnt == ones(r_r.wide)) ||
                  (r_r.cnt <= r_r.blocks)))
              r_nxt.err = 1'b1;
          end
        end
        ST_PHDR:
        begin
          r_nxt.pcode = b[5:0];
          r_nxt.st = ST_PLEN;
          if (b[PS_BIT] || b[SPF_BIT] || !supported(b[5:0]))
            r_nxt.err = 1'b1;
        end
        ST_PLEN:
        begin
          r_nxt.plen = b;
          r_nxt.idx = '0;
          r_nxt.st = (b == 8'h00) ? ST_PHDR : ST_BODY;
          if (b != page_len(r_r.pcode))
            r_nxt.err = 1'b1;
        end
        ST_BODY:
        begin
          if (r_r.pcode == PG_VU && r_r.plen == PLEN_VU)
          begin
            r_nxt.stage[4'(r_r.idx + BODY_OFS)] =
              b & PG0_WMASK[4'(r_r.idx + BODY_OFS)];
            if ((b & ~PG0_WMASK[4'(r_r.idx + BODY_OFS)]) != 8'h00)
              r_nxt.err = 1'b1;
          end
          if (r_r.idx == r_r.plen - 8'h01)
            r_nxt.st = ST_PHDR;
        end
        default: r_nxt.st = ST_FLAGS;
      endcase
      if (LINK.sel_last)
      begin
        r_nxt.done = 1'b1;
        r_nxt.check = r_nxt.err || (r_nxt.st != ST_PHDR);
        r_nxt.st = ST_FLAGS;
        r_nxt.idx = '0;
        if (!r_nxt.check)
        begin
          r_nxt.cur = r_nxt.stage;
          if (r_r.dlen != DLEN_NONE)
          begin
            if (r_nxt.blen == '0 || r_nxt.blen == r_nxt.cur_blen)
              r_nxt.blocks = apply_cnt(r_nxt.cnt, r_r.wide, r_nxt.blocks);
            else
            begin
              r_nxt.pend = 1'b1;
              r_nxt.pend_cnt = r_nxt.cnt;
              r_nxt.pend_wide = r_r.wide;
              r_nxt.pend_blen = r_nxt.blen;
            end
          end
          r_nxt.armed = r_nxt.stage[SEEK_BYTE][SEEK_BIT] &&
                        (r_r.armed || r_r.spin);
          if (!r_nxt.stage[SEEK_BYTE][SEEK_BIT])
            r_nxt.seek = 1'b0;
        end
      end
    end
    else if (r_r.st == ST_FLAGS && LINK.sense_req)
    begin
      r_nxt.st = ST_SENSE;
      r_nxt.idx = '0;
      r_nxt.wide = LINK.sense_wide;
    end
    else if (r_r.st == ST_SENSE)
    begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata = sense_byte(r_r.idx, r_r.wide, r_r);
      r_nxt.idx = r_r.idx + 8'h01;
      if (r_r.idx == (r_r.wide ? DLEN_LONG : DLEN_SHORT) + 8'h0F)
      begin
        r_nxt.rlast = 1'b1;
        r_nxt.st = ST_FLAGS;
        r_nxt.idx = '0;
      end
    end
    if (I_STOP_UNIT)
      r_nxt.spin = 1'b0;
    if (I_START_UNIT)
    begin
      r_nxt.spin = 1'b1;
      if (!r_r.spin && r_r.armed)
        r_nxt.seek = 1'b1;
    end
    r_nxt.ndr = I_NONDATA_ERR && I_PER_ENABLE &&
                r_r.cur[SEEK_BYTE][RRND_BIT];
    r_nxt.tur = I_FORMAT_DEGRADED && !r_r.cur[FDD_BYTE][FDD_BIT];
    r_nxt.media = I_FORMAT_DEGRADED;
    r_nxt.fifo = r_r.cur[FDD_BYTE][QUEUE_AGING_ENABLE_BIT] &&
                 (I_QUEUE_WAIT > {r_r.cur[AGE_HI], r_r.cur[AGE_LO]});
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SYS_RST)
    begin
      r_r <= '0;
      r_r.st <= ST_FLAGS;
      r_r.cur <= PG0_DFLT;
      r_r.stage <= PG0_DFLT;
      r_r.blocks <= MAX_BLOCKS;
      r_r.cur_blen <= BLEN_RESET;
      r_r.spin <= 1'b1;
    end
    else
      r_r <= r_nxt;
  end

  assign LINK.rsp_valid = r_r.rvalid;
  assign LINK.rsp_data = r_r.rdata;
  assign LINK.rsp_last = r_r.rlast;
  assign LINK.done = r_r.done;
  assign LINK.check = r_r.check;
  assign LINK.sense_key = r_r.check ? KEY_ILLEGAL : 4'h0;
  assign LINK.asc = r_r.check ? ASC_BAD_PARAM : 8'h00;
  assign O_USER_BLOCKS = r_r.blocks;
  assign O_BLOCK_LENGTH = r_r.cur_blen;
  assign O_FORMAT_PENDING = r_r.pend;
  assign O_DEFECT_MERGE = r_r.merge;
  assign O_SELF_SEEK = r_r.seek;
  assign O_NONDATA_REPORT = r_r.ndr;
  assign O_TUR_DEGRADED = r_r.tur;
  assign O_MEDIA_DEGRADED = r_r.media;
  assign O_QUEUE_FIFO = r_r.fifo;
endmodule

// >>> design/mpc_host.sv
// Initiator end: Wishbone registers drive MODE SELECT and MODE SENSE.
`timescale 1ns/1ps
module mpc_host
  import mpc_pkg::*;
#(
  parameter int unsigned DEPTH = BUF_DEPTH
)(
  // Clock and reset.
  input  wire logic        I_REF_CLK,
  input  wire logic        I_SYS_RST,
  // Wishbone slave.
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // Link to the device.
  mpc_link_if.host         LINK
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SEND  = 2'b01,
    HS_WAIT  = 2'b10,
    HS_SENSE = 2'b11
  } mpc_hst_t;

  typedef struct packed {
    mpc_hst_t                st;
    logic [7:0]              idx;
    logic [7:0]              len;
    logic                    wide;
    logic                    check;
    logic [3:0]              key;
    logic [7:0]              asc;
    logic [7:0]              rxn;
    logic                    req;
    logic                    ack;
    logic [31:0]             dat;
    logic [0:DEPTH-1][7:0]   buf_b;
  } mpc_hstate_t;

  mpc_hstate_t r_r;
  mpc_hstate_t r_nxt;
  logic        wb_take;
  logic        in_buf;
  logic [AW-1:0] wb_idx;

  assign wb_take = I_WB_CYC && I_WB_STB && !r_r.ack;
  assign in_buf = I_WB_ADR >= ADR_BUF;
  assign wb_idx = AW'((I_WB_ADR - ADR_BUF) >> 2);

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.ack = wb_take;
    r_nxt.req = 1'b0;
    if (wb_take && !I_WB_WE)
    begin
      if (in_buf)
        r_nxt.dat = {24'h00_0000, r_r.buf_b[wb_idx]};
      else if (I_WB_ADR == ADR_CTRL)
        r_nxt.dat = {29'h0000_0000, r_r.wide, 2'b00};
      else if (I_WB_ADR == ADR_LEN)
        r_nxt.dat = {24'h00_0000, r_r.len};
      else if (I_WB_ADR == ADR_STATUS)
        r_nxt.dat = {r_r.rxn, r_r.asc, 4'h0, r_r.key, 6'h00, r_r.check,
                     r_r.st != HS_IDLE};
      else
        r_nxt.dat = 32'h0000_0000;
    end
    if (wb_take && I_WB_WE && I_WB_SEL[0])
    begin
      if (in_buf)
        r_nxt.buf_b[wb_idx] = I_WB_DAT[7:0];
      else if (I_WB_ADR == ADR_LEN)
        r_nxt.len = I_WB_DAT[7:0];
      else if (I_WB_ADR == ADR_CTRL && r_r.st == HS_IDLE)
      begin
        r_nxt.wide = I_WB_DAT[CTRL_WIDE];
        if (I_WB_DAT[CTRL_SEL] && r_r.len != 8'h00)
        begin
          r_nxt.st = HS_SEND;
          r_nxt.idx = '0;
        end
        else if (I_WB_DAT[CTRL_SENSE])
        begin
          r_nxt.st = HS_SENSE;
          r_nxt.req = 1'b1;
          r_nxt.rxn = '0;
          r_nxt.check = 1'b0;
        end
      end
    end
    unique case (r_r.st)
      HS_IDLE: ;
      HS_SEND:
        if (LINK.sel_ready)
        begin
          r_nxt.idx = r_r.idx + 8'h01;
          if (r_r.idx == r_r.len - 8'h01)
            r_nxt.st = HS_WAIT;
        end
      HS_WAIT:
        if (LINK.done)
        begin
          r_nxt.st = HS_IDLE;
          r_nxt.check = LINK.check;
          r_nxt.key = LINK.sense_key;
          r_nxt.asc = LINK.asc;
        end
      HS_SENSE:
        if (LINK.rsp_valid)
        begin
          if (r_r.rxn < 8'(DEPTH))
          begin
            r_nxt.buf_b[AW'(r_r.rxn)] = LINK.rsp_data;
            r_nxt.rxn = r_r.rxn + 8'h01;
          end
          if (LINK.rsp_last)
            r_nxt.st = HS_IDLE;
        end
    endcase
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SYS_RST)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  // The flag byte carries the descriptor format only, savable clear.
  assign LINK.sel_valid = r_r.st == HS_SEND;
  assign LINK.sel_data = r_r.buf_b[AW'(r_r.idx)];
  assign LINK.sel_last = (r_r.st == HS_SEND) &&
                         (r_r.idx == r_r.len - 8'h01);
  assign LINK.sense_req = r_r.req;
  assign LINK.sense_wide = r_r.wide;
  assign O_WB_DAT = r_r.dat;
  assign O_WB_ACK = r_r.ack;
endmodule

// >>> dv/mpc_monitor.sv
// Concurrent checks on the link between the initiator and device ends.
`timescale 1ns/1ps
module mpc_monitor
  import mpc_pkg::*;
(
  // Clock and reset.
  input wire logic       I_REF_CLK,
  input wire logic       I_SYS_RST,
  // Select stream.
  input wire logic       sel_valid,
  input wire logic       sel_ready,
  input wire logic [7:0] sel_data,
  input wire logic       sel_last,
  // Sense stream.
  input wire logic       sense_req,
  input wire logic       sense_wide,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  // Completion status.
  input wire logic       done,
  input wire logic       check,
  input wire logic [3:0] sense_key,
  input wire logic [7:0] asc
);
  logic [5:0] idx_r;
  logic [5:0] page_at;

  default clocking mon_cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  // Position of the current byte within a sense answer.
  always_ff @(posedge I_REF_CLK)
    if (I_SYS_RST || (rsp_valid && rsp_last))
      idx_r <= 6'h00;
    else if (rsp_valid)
      idx_r <= idx_r + 6'h01;
  assign page_at = sense_wide ? 6'h10 : 6'h08;

  a_sense_start: assert property (sense_req |-> ##2 rsp_valid)
    else $error("sense answer did not start in time");
  a_sense_length: assert property (rsp_valid && rsp_last |->
    idx_r == (sense_wide ? 6'h1F : 6'h17))
    else $error("sense answer has the wrong length");
  a_page_code: assert property (rsp_valid && idx_r == page_at |->
    rsp_data == 8'h80)
    else $error("sensed page header byte wrong");
  a_page_len: assert property (rsp_valid && idx_r == page_at + 6'h01
    |-> rsp_data == PLEN_VU)
    else $error("sensed page length wrong");
  a_resv_zero: assert property (rsp_valid && (sense_wide ?
    idx_r[5:2] == 4'h2 : idx_r == 6'h04) |-> rsp_data == 8'h00)
    else $error("reserved descriptor byte not zero");
  a_done_after: assert property (sel_valid && sel_ready && sel_last
    |=> done)
    else $error("select end not followed by done");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_check_code: assert property (check |->
    sense_key == KEY_ILLEGAL && asc == ASC_BAD_PARAM)
    else $error("check without illegal request sense");
  a_clear_code: assert property (!check |->
    sense_key == 4'h0 && asc == 8'h00)
    else $error("sense code without check");
  a_check_hold: assert property ($changed(check) |-> done)
    else $error("check changed outside done");

  cover property (done && check);
  cover property (done && !check);
  cover property (rsp_valid && rsp_last && sense_wide);
endmodule

// >>> dv/mode_parameter_checker_test.sv
// Self-checking bench driving both ends of the mode parameter link.
`timescale 1ns/1ps
module mode_parameter_checker_test
  import mpc_pkg::*;
;
  localparam logic [63:0] MAXB = 64'h0000_0000_0000_1000;
  logic        clk, rst, cyc, stb, wen, ack, per, deg;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0]  ev, wsel;
  logic [15:0] qw;
  logic [63:0] blocks, eb, rc;
  logic [23:0] blen, el, nl;
  logic        pend, merge, seek, nrep, tur, media, fifo, ep;
  mpc_page_t   pb, cp;
  int          seed;
  int          fail_count;
  int          samples_checked;
  int          ticks = 0;
  logic [23:0] lens [8] = '{BLEN_520, BLEN_528, BLEN_4096, BLEN_4112,
    BLEN_4160, BLEN_4224, 24'h00_03E8, 24'h00_0201};

  mpc_link_if link ();
  mpc_host mpc_host_i (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(wen), .I_WB_ADR(adr), .I_WB_SEL(wsel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .LINK(link));
  mpc_device #(.MAX_BLOCKS(MAXB)) mpc_device_i (.I_REF_CLK(clk),
    .I_SYS_RST(rst), .LINK(link), .I_FORMAT_UNIT(ev[0]),
    .I_STOP_UNIT(ev[1]), .I_START_UNIT(ev[2]), .I_PER_ENABLE(per),
    .I_NONDATA_ERR(ev[3]), .I_FORMAT_DEGRADED(deg), .I_QUEUE_WAIT(qw),
    .O_USER_BLOCKS(blocks), .O_BLOCK_LENGTH(blen), .O_FORMAT_PENDING(pend),
    .O_DEFECT_MERGE(merge), .O_SELF_SEEK(seek), .O_NONDATA_REPORT(nrep),
    .O_TUR_DEGRADED(tur), .O_MEDIA_DEGRADED(media), .O_QUEUE_FIFO(fifo));
  mpc_monitor mpc_monitor_i (.I_REF_CLK(clk), .I_SYS_RST(rst),
    .sel_valid(link.sel_valid), .sel_ready(link.sel_ready),
    .sel_data(link.sel_data), .sel_last(link.sel_last),
    .sense_req(link.sense_req), .sense_wide(link.sense_wide),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
    .rsp_last(link.rsp_last), .done(link.done), .check(link.check),
    .sense_key(link.sense_key), .asc(link.asc));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // Expected user blocks after an accepted descriptor count.
  function automatic logic [63:0] exp_blocks(input logic [63:0] c,
      input logic [63:0] all, input logic [63:0] cur);
    return (c == 64'h0) ? cur : (c == all) ? MAXB : c;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One classic Wishbone cycle; the request stands until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    wdat <= d;
    wsel <= 4'h1;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic run(input logic [31:0] ctrl, output logic [31:0] st);
    wb(1'b1, ADR_CTRL, ctrl, st);
    do
      wb(1'b0, ADR_STATUS, 32'h0, st);
    while (st[0] !== 1'b0);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask

  task automatic sel(input logic [63:0] c, input logic [23:0] l,
                     input logic [7:0] dl, input logic [7:0] pg,
                     input logic [7:0] pl, input logic ex);
    logic [7:0]   q[$];
    logic [127:0] dv;
    logic [31:0]  st;
    logic [63:0]  ones;
    ones = (dl == DLEN_LONG) ? CNT_ONES_LONG : CNT_ONES_SHORT;
    dv = (dl == DLEN_LONG) ? {c, 32'h0, 8'h0, l} : {c[31:0], 8'h0, l, 64'h0};
    q.push_back({7'h0, dl == DLEN_LONG});
    q.push_back(dl);
    for (int i = 0; i < dl; i++)
      q.push_back(dv[127 - 8 * i -: 8]);
    if (pg != 8'hFF)
    begin
      q.push_back(pg);
      q.push_back(pl);
      for (int i = 0; i < pl; i++)
        q.push_back(pb[2 + i]);
    end
    foreach (q[i])
      wb(1'b1, 8'(ADR_BUF + 4 * i), {24'h0, q[i]}, st);
    wb(1'b1, ADR_LEN, 32'(q.size()), st);
    run(32'h1, st);
    chk(st[1], ex);
    chk({st[23:16], st[11:8]}, ex ? 12'h265 : 12'h000);
    if (!ex && pg == 8'h00)
      cp = pb;
    if (!ex && dl != 8'h00)
      if (l == 24'h0 || l == el)
        eb = exp_blocks(c, ones, eb);
      else
      begin
        ep = 1'b1;
        nl = l;
      end
    tick(1);
    chk(blocks, eb);
    chk(blen, el);
    chk(pend, ep);
  endtask

  task automatic sense(input logic w);
    logic [255:0] es;
    logic [31:0]  st;
    logic [7:0]   n;
    es = w ? {eb, 32'h0, 8'h0, el, 8'h80, PLEN_VU, cp[2:15]}
           : {eb[31:0], 8'h0, el, 8'h80, PLEN_VU, cp[2:15], 64'h0};
    n = w ? 8'h20 : 8'h18;
    run({29'h0, w, 2'h2}, st);
    chk(st[31:24], n);
    for (int i = 0; i < n; i++)
    begin
      wb(1'b0, 8'(ADR_BUF + 4 * i), 32'h0, st);
      chk(st[7:0], es[255 - 8 * i -: 8]);
    end
  endtask

  initial
  begin
    {rst, cyc, stb, wen, adr, wdat, ev, wsel, per, deg, qw} = '0;
    rst = 1'b1;
    seed = 18990;
    fail_count = 0;
    samples_checked = 0;
    {eb, el, ep, nl, cp, pb} = {MAXB, BLEN_RESET, 1'b0, 24'h0, PG0_DFLT,
      PG0_DFLT};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    sense(1'b0);
    sense(1'b1);
    sel(64'h0, BLEN_512, DLEN_SHORT, 8'hFF, 8'h00, 1'b0);
    sel(64'h800, 24'h0, DLEN_SHORT, 8'hFF, 8'h00, 1'b0);
    sel(64'h801, 24'h0, DLEN_SHORT, 8'hFF, 8'h00, 1'b1);
    sel(64'hFFFF_FFFF, 24'h0, DLEN_SHORT, 8'hFF, 8'h00, 1'b0);
    sel(64'h10, BLEN_512, DLEN_LONG, 8'hFF, 8'h00, 1'b0);
    sense(1'b1);
    sel('1, 24'h0, DLEN_LONG, 8'hFF, 8'h00, 1'b0);
    sel(64'h0, 24'h0, 8'h05, 8'hFF, 8'h00, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      rc = 64'($random(seed)) & 64'h1FFF;
      sel(rc, 24'h0, DLEN_SHORT, 8'hFF, 8'h00, rc > eb);
    end
    for (int i = 2; i < 16; i++)
      pb[i] = 8'($random(seed)) & PG0_WMASK[i];
    pb[MERGE_BYTE][MERGE_BIT] = 1'b1;
    pb[SEEK_BYTE][SEEK_BIT] = 1'b1;
    pb[SEEK_BYTE][RRND_BIT] = 1'b1;
    pb[FDD_BYTE][FDD_BIT] = 1'b1;
    pb[FDD_BYTE][QUEUE_AGING_ENABLE_BIT] = 1'b1;
    pb[AGE_HI] = 8'h00;
    pb[AGE_LO] = 8'h40;
    sel(64'h0, 24'h0, DLEN_NONE, 8'h80, PLEN_VU, 1'b1);
    sel(64'h0, 24'h0, DLEN_NONE, 8'h40, PLEN_VU, 1'b1);
    sel(64'h0, 24'h0, DLEN_NONE, 8'h05, PLEN_DFLT, 1'b1);
    sel(64'h0, 24'h0, DLEN_NONE, 8'h00, 8'h0D, 1'b1);
    sel(64'h0, 24'h0, DLEN_NONE, 8'h00, PLEN_VU, 1'b0);
    sense(1'b0);
    wb(1'b1, 8'h40, 32'h0000_00FF, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 64'h0);
    foreach (lens[i])
      sel(64'h0, lens[i], DLEN_SHORT, 8'hFF, 8'h00, i > 5);
    chk(seek, 1'b0);
    pulse(4'h1);
    chk(merge, 1'b1);
    chk({blen, pend}, {nl, 1'b0});
    pulse(4'h2);
    pulse(4'h4);
    tick(2);
    chk(seek, 1'b1);
    per <= 1'b1;
    pulse(4'h8);
    chk(nrep, 1'b1);
    per <= 1'b0;
    pulse(4'h8);
    chk(nrep, 1'b0);
    deg <= 1'b1;
    qw <= 16'h0040;
    tick(2);
    chk({tur, media, fifo}, 3'b010);
    qw <= 16'h0041;
    tick(2);
    chk(fifo, 1'b1);
    give_verdict();
  end
endmodule
